// [design/tdpc_db_if.sv]
/*
  link between the timer core and one deadband stage.
  assumes both ends share the timer clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tdpc_db_if;
  logic       lvl;
  logic [7:0] dly;
  logic       out;
  modport dut  (input lvl, input dly, output out);
  modport core (output lvl, output dly, input out);
endinterface : tdpc_db_if
`default_nettype wire

// [design/tdpc_deadband.sv]
/*
  deadband stage: delays rising edges of one level, falls at once.
  assumes dly is held stable while the level is high.
*/
`timescale 1ns/1ps
`default_nettype none
module tdpc_deadband
  import tdpc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  tdpc_db_if.dut    port
);
  typedef struct packed {
    logic [7:0] cnt;
  } tdpc_db_st_t;

  tdpc_db_st_t st_r;
  tdpc_db_st_t st_nxt;

  // combinational so a zero delay passes the edge in the same cycle
  assign port.out = port.lvl && (st_r.cnt >= port.dly);

  always_comb begin
    st_nxt = st_r;
    if (!port.lvl) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt < port.dly) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule : tdpc_deadband
`default_nettype wire

// [design/tdpc_pkg.sv]
/*
  constants, codes and register map of the dual pwm / capture timer.
  assumes a 32-bit apb slave where each 8-bit register takes one word.
*/
package tdpc_pkg;
  localparam logic [7:0]  OFS_CTL0   = 8'h00;
  localparam logic [7:0]  OFS_CTL1   = 8'h04;
  localparam logic [7:0]  OFS_CNT_H  = 8'h08;
  localparam logic [7:0]  OFS_CNT_L  = 8'h0c;
  localparam logic [7:0]  OFS_RLD_H  = 8'h10;
  localparam logic [7:0]  OFS_RLD_L  = 8'h14;
  localparam logic [7:0]  OFS_PWM_H  = 8'h18;
  localparam logic [7:0]  OFS_PWM_L  = 8'h1c;
  localparam logic [7:0]  OFS_DB     = 8'h20;
  // timer_control_zero fields
  localparam int          C0_MODEX   = 0;
  localparam int          C0_SRC_LSB = 1;
  localparam int          C0_CAUSE   = 3;
  // timer_control_one fields
  localparam int          C1_MODE_LSB = 0;
  localparam int          C1_PRE_LSB  = 3;
  localparam int          C1_POL      = 6;
  localparam int          C1_EN       = 7;
  localparam logic [7:0]  CTL0_RST   = 8'h00;
  localparam logic [7:0]  CTL1_RST   = 8'h00;
  localparam logic [15:0] CNT_RST    = 16'h0001;
  localparam logic [15:0] RLD_RST    = 16'hffff;
  localparam logic [15:0] PWM_RST    = 16'h0000;
  localparam logic [15:0] CNT_START  = 16'h0001;
  localparam logic [7:0]  DB_RST     = 8'h00;
  localparam logic [7:0]  DB_MAX     = 8'h80;
  // combined {mode_extension_bit, timer_mode_field}
  localparam logic [3:0]  CODE_DPWM  = 4'h8;
  localparam logic [3:0]  CODE_CAP   = 4'h4;
  localparam logic [3:0]  CODE_CAPRS = 4'h9;
  // interrupt_source_select
  localparam logic [1:0]  SRC_CAP    = 2'h1;
  localparam logic [1:0]  SRC_RLD    = 2'h2;
  typedef enum logic [1:0] {
    TDPC_OFF   = 2'b00,
    TDPC_DPWM  = 2'b01,
    TDPC_CAP   = 2'b10,
    TDPC_CAPRS = 2'b11
  } tdpc_mode_t;
endpackage : tdpc_pkg

// [design/tdpc_timer.sv]
/*
  16-bit dual pwm / capture / capture-restart timer with apb registers.
  assumes a zero-wait apb master and an external pad that resolves
  tcmp_o / tcmp_oe against tin_i on the shared pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tdpc_timer
  import tdpc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              tin_i,
  output logic                   tout_o,
  output logic                   tout_oe,
  output logic                   tcmp_o,
  output logic                   tcmp_oe,
  output logic                   timer_irq
);
  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] pwm;
    logic [7:0]  hold;
    logic [7:0]  db;
    logic [6:0]  pre;
    logic [2:0]  sync;
    logic        lvl;
    logic        pwm_lvl;
    logic        irq;
    logic        tout;
    logic        tout_oe;
    logic        tcmp;
    logic        tcmp_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tdpc_st_t;

  tdpc_st_t   st_r;
  tdpc_st_t   st_nxt;
  tdpc_mode_t mode;
  logic       en;
  logic       pol;
  logic [1:0] src;
  logic [6:0] lim;
  logic       tick;
  logic       sel_edge;
  logic       cap_ev;
  logic       rl_ev;
  logic       wr;
  logic       rd;
  logic [7:0] a;
  logic [1:0] db_out;

  tdpc_db_if dbi[2] ();

  // one stage per pin; the second sees the inverted waveform
  for (genvar i = 0; i < 2; i++) begin : g_db
    assign dbi[i].lvl = (i == 0) ? st_r.pwm_lvl : !st_r.pwm_lvl;
    assign dbi[i].dly = st_r.db;
    assign db_out[i]  = dbi[i].out;
    tdpc_deadband u_db (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .port (dbi[i].dut)
    );
  end

  always_comb begin
    st_nxt = st_r;
    en     = st_r.ctl1[C1_EN];
    pol    = st_r.ctl1[C1_POL];
    src    = st_r.ctl0[C0_SRC_LSB +: 2];
    a      = paddr[7:0];
    wr     = psel && penable && pwrite;
    rd     = psel && !penable && !pwrite;
    tick   = 1'b0;
    case ({st_r.ctl0[C0_MODEX], st_r.ctl1[C1_MODE_LSB +: 3]})
      CODE_DPWM:  mode = TDPC_DPWM;
      CODE_CAP:   mode = TDPC_CAP;
      CODE_CAPRS: mode = TDPC_CAPRS;
      default:    mode = TDPC_OFF;
    endcase

    // pin input: only the second and third stages are compared
    st_nxt.sync = {st_r.sync[1:0], tin_i};
    if (st_r.sync[1] == st_r.sync[2]) begin
      st_nxt.lvl = st_r.sync[2];
    end
    // polarity 0 captures rising, 1 falling
    sel_edge = (st_r.sync[1] == st_r.sync[2]) && (st_r.sync[2] != st_r.lvl)
               && (st_r.sync[2] == !pol);
    // the pin is an output in dual pwm, so no capture there
    cap_ev = en && (mode == TDPC_CAP || mode == TDPC_CAPRS) && sel_edge;

    // prescaler: divide by 2**pre, system clock is the only source
    lim = 7'((8'h01 << st_r.ctl1[C1_PRE_LSB +: 3]) - 8'h01);
    if (en && mode != TDPC_OFF) begin
      if (st_r.pre >= lim) begin
        st_nxt.pre = 7'h00;
        tick       = 1'b1;
      end else begin
        st_nxt.pre = st_r.pre + 7'h01;
      end
    end else begin
      st_nxt.pre = 7'h00;
    end
    rl_ev = tick && (st_r.cnt == st_r.rld);

    // bus writes first so that hardware events below take priority
    st_nxt.pready  = psel && !penable;
    st_nxt.pslverr = 1'b0;
    if (wr) begin
      case (a)
        OFS_CTL0:  st_nxt.ctl0 = {pwdata[7:4], st_r.ctl0[C0_CAUSE], pwdata[2:0]};
        OFS_CTL1:  st_nxt.ctl1 = pwdata[7:0];
        OFS_CNT_H: st_nxt.cnt[15:8] = pwdata[7:0];
        OFS_CNT_L: st_nxt.cnt[7:0] = pwdata[7:0];
        OFS_RLD_H: st_nxt.rld[15:8] = pwdata[7:0];
        OFS_RLD_L: st_nxt.rld[7:0] = pwdata[7:0];
        OFS_PWM_H: st_nxt.pwm[15:8] = pwdata[7:0];
        OFS_PWM_L: st_nxt.pwm[7:0] = pwdata[7:0];
        OFS_DB:    st_nxt.db = (pwdata[7:0] > DB_MAX) ? DB_MAX : pwdata[7:0];
        default:   st_nxt.db = st_r.db;
      endcase
    end
    // latched at setup, the same sample the high byte is staged from
    if (rd && a == OFS_CNT_H && en) begin
      st_nxt.hold = st_r.cnt[7:0];
    end
    // read data staged in the setup cycle, so prdata is a flop
    st_nxt.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      case (a)
        OFS_CTL0:  st_nxt.prdata[7:0] = st_r.ctl0;
        OFS_CTL1:  st_nxt.prdata[7:0] = st_r.ctl1;
        OFS_CNT_H: st_nxt.prdata[7:0] = st_r.cnt[15:8];
        OFS_CNT_L: st_nxt.prdata[7:0] = en ? st_r.hold : st_r.cnt[7:0];
        OFS_RLD_H: st_nxt.prdata[7:0] = st_r.rld[15:8];
        OFS_RLD_L: st_nxt.prdata[7:0] = st_r.rld[7:0];
        OFS_PWM_H: st_nxt.prdata[7:0] = st_r.pwm[15:8];
        OFS_PWM_L: st_nxt.prdata[7:0] = st_r.pwm[7:0];
        OFS_DB:    st_nxt.prdata[7:0] = st_r.db;
        default:   st_nxt.pslverr = 1'b1;
      endcase
    end

    // counter; a written start value only lasts until the first reload, except in capture mode, where the count runs on past it
    if (tick) begin
      if (rl_ev && mode != TDPC_CAP) begin
        st_nxt.cnt = CNT_START;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end
    if (cap_ev) begin
      st_nxt.pwm            = st_r.cnt;
      st_nxt.ctl0[C0_CAUSE] = 1'b1;
      if (mode == TDPC_CAPRS) begin
        st_nxt.cnt = CNT_START;
        st_nxt.pre = 7'h00;
      end
    end else if (rl_ev && mode != TDPC_DPWM) begin
      st_nxt.ctl0[C0_CAUSE] = 1'b0;
    end

    // pwm level: starts at polarity, toggles on match, back on reload
    if (!en || mode != TDPC_DPWM || rl_ev) begin
      st_nxt.pwm_lvl = pol;
    end else if (tick && st_r.cnt == st_r.pwm) begin
      st_nxt.pwm_lvl = !st_r.pwm_lvl;
    end

    // dual pwm reloads always interrupt; capture modes obey the select
    st_nxt.irq = (rl_ev && (mode == TDPC_DPWM || src != SRC_CAP))
                 || (cap_ev && src != SRC_RLD);

    st_nxt.tout_oe = (mode == TDPC_DPWM);
    st_nxt.tcmp_oe = (mode == TDPC_DPWM);
    st_nxt.tout    = (mode == TDPC_DPWM) && db_out[0];
    st_nxt.tcmp    = (mode == TDPC_DPWM) && db_out[1];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r         <= '0;
      st_r.ctl0    <= CTL0_RST;
      st_r.ctl1    <= CTL1_RST;
      st_r.cnt     <= CNT_RST;
      st_r.rld     <= RLD_RST;
      st_r.pwm     <= PWM_RST;
      st_r.db      <= DB_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign prdata    = st_r.prdata;
  assign pready    = st_r.pready;
  assign pslverr   = st_r.pslverr;
  assign tout_o    = st_r.tout;
  assign tout_oe   = st_r.tout_oe;
  assign tcmp_o    = st_r.tcmp;
  assign tcmp_oe   = st_r.tcmp_oe;
  assign timer_irq = st_r.irq;

  // checks; every antecedent needs ce because state freezes without it
  property p_reload_start;
    @(posedge clk) disable iff (rst)
    ce && rl_ev && mode == TDPC_DPWM |=> st_r.cnt == CNT_START && timer_irq;
  endproperty
  a_reload_start: assert property (p_reload_start) else $error("reload did not restart count");

  property p_match_toggle;
    @(posedge clk) disable iff (rst)
    ce && en && mode == TDPC_DPWM && tick && !rl_ev && st_r.cnt == st_r.pwm
    |=> st_r.pwm_lvl != $past(st_r.pwm_lvl);
  endproperty
  a_match_toggle: assert property (p_match_toggle) else $error("no toggle on match");

  property p_pol_high;
    @(posedge clk) disable iff (rst)
    ce && rl_ev && mode == TDPC_DPWM && pol |=> st_r.pwm_lvl;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("level not high after reload");

  property p_pol_low;
    @(posedge clk) disable iff (rst)
    ce && rl_ev && mode == TDPC_DPWM && !pol |=> !st_r.pwm_lvl;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("level not low after reload");

  property p_no_overlap;
    @(posedge clk) disable iff (rst)
    !(tout_o && tcmp_o);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both pwm pins active");

  property p_zero_db;
    @(posedge clk) disable iff (rst)
    ce && st_r.db == 8'h00 && mode == TDPC_DPWM |=> tcmp_o == !tout_o;
  endproperty
  a_zero_db: assert property (p_zero_db) else $error("zero deadband delayed a pin");

  property p_cap_store;
    @(posedge clk) disable iff (rst)
    ce && cap_ev |=> st_r.pwm == $past(st_r.cnt) && st_r.ctl0[C0_CAUSE];
  endproperty
  a_cap_store: assert property (p_cap_store) else $error("capture not stored");

  property p_caprs_restart;
    @(posedge clk) disable iff (rst)
    ce && cap_ev && mode == TDPC_CAPRS |=> st_r.cnt == CNT_START;
  endproperty
  a_caprs_restart: assert property (p_caprs_restart) else $error("no restart on capture");

  property p_cap_reload;
    @(posedge clk) disable iff (rst)
    ce && rl_ev && !cap_ev && mode == TDPC_CAP
    |=> !st_r.ctl0[C0_CAUSE] && st_r.cnt == $past(st_r.cnt) + 16'h0001;
  endproperty
  a_cap_reload: assert property (p_cap_reload) else $error("capture reload wrong");

  property p_src_cap_only;
    @(posedge clk) disable iff (rst)
    ce && rl_ev && !cap_ev && mode == TDPC_CAP && src == SRC_CAP |=> !timer_irq;
  endproperty
  a_src_cap_only: assert property (p_src_cap_only) else $error("reload irq not masked");

  property p_pin_dir;
    @(posedge clk) disable iff (rst)
    ce && mode == TDPC_DPWM |=> tcmp_oe;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("shared pin not driven");

  property p_caprs_reload;
    @(posedge clk) disable iff (rst)
    ce && rl_ev && !cap_ev && mode == TDPC_CAPRS
    |=> st_r.cnt == CNT_START && !st_r.ctl0[C0_CAUSE];
  endproperty
  a_caprs_reload: assert property (p_caprs_reload) else $error("restart reload wrong");

  property p_hold_latch;
    @(posedge clk) disable iff (rst)
    ce && rd && a == OFS_CNT_H && en |=> st_r.hold == $past(st_r.cnt[7:0]);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("low byte not held");

  property p_cap_masked;
    @(posedge clk) disable iff (rst)
    ce && cap_ev && !rl_ev && src == SRC_RLD |=> !timer_irq;
  endproperty
  a_cap_masked: assert property (p_cap_masked) else $error("capture irq not masked");

  c_dpwm_reload: cover property (@(posedge clk) rl_ev && mode == TDPC_DPWM);
  c_capture: cover property (@(posedge clk) cap_ev && mode == TDPC_CAP);
  c_caprs: cover property (@(posedge clk) cap_ev && mode == TDPC_CAPRS);
endmodule : tdpc_timer
`default_nettype wire

// [sim/tdpc_pins.sv]
/*
  pin model: shared timer pin and primary output pad.
  assumes a pull-up on the primary pad while undriven.
*/
`timescale 1ns/1ps
`default_nettype none
module tdpc_pins (
  input  wire logic tout_o,
  input  wire logic tout_oe,
  input  wire logic tcmp_o,
  input  wire logic tcmp_oe,
  input  wire logic drv_lvl,
  output logic      tin_i,
  output logic      pin_out,
  output logic      pin_cmp
);
  // shared pin: complement in dual pwm, bench level otherwise
  assign pin_cmp = tcmp_oe ? tcmp_o : drv_lvl;
  assign tin_i   = pin_cmp;
  assign pin_out = tout_oe ? tout_o : 1'b1;
endmodule : tdpc_pins
`default_nettype wire

// [sim/tdpc_timer_tb_top.sv]
/*
  self-checking bench for the dual pwm / capture timer.
  assumes the pin model and the registered apb slave.
*/
`timescale 1ns/1ps
`default_nettype none
module tdpc_timer_tb_top;
  import tdpc_pkg::*;
  logic        clk, rst, ce, psel, penable, pwrite, tin_lvl, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, tin_i, tout_o, tout_oe;
  logic        tcmp_o, tcmp_oe, timer_irq, pin_out, pin_cmp;
  int          miscompares, compares;

  tdpc_timer tdpc_timer_inst (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tin_i(tin_i), .tout_o(tout_o),
    .tout_oe(tout_oe), .tcmp_o(tcmp_o), .tcmp_oe(tcmp_oe),
    .timer_irq(timer_irq));
  tdpc_pins tdpc_pins_inst (
    .tout_o(tout_o), .tout_oe(tout_oe), .tcmp_o(tcmp_o),
    .tcmp_oe(tcmp_oe), .drv_lvl(tin_lvl), .tin_i(tin_i),
    .pin_out(pin_out), .pin_cmp(pin_cmp));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  // bounded wait: a hung handshake ends the run
  task automatic wait_for(input string nm, ref logic s, input int lim);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin
      chk(nm, 16'h0001, 16'h0000);
      conclude();
    end
  endtask : wait_for

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    wait_for("pready", pready, 20);
    q = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr16(input logic [7:0] h, input logic [7:0] l, input logic [15:0] v);
    logic [7:0] q;
    apb(1'b1, h, v[15:8], q);
    apb(1'b1, l, v[7:0], q);
  endtask : wr16

  task automatic rd16(input logic [7:0] h, input logic [7:0] l, output logic [15:0] v);
    apb(1'b0, h, 8'h00, v[15:8]);
    apb(1'b0, l, 8'h00, v[7:0]);
  endtask : rd16

  // disable first, enable is a separate last write
  task automatic cfg(input logic [7:0] c0, input logic [15:0] pw, input logic [15:0] rl,
                     input logic [15:0] cn);
    logic [7:0] q;
    apb(1'b1, OFS_CTL1, 8'h00, q);
    apb(1'b1, OFS_CTL0, c0, q);
    wr16(OFS_PWM_H, OFS_PWM_L, pw);
    wr16(OFS_RLD_H, OFS_RLD_L, rl);
    wr16(OFS_CNT_H, OFS_CNT_L, cn);
  endtask : cfg

  task automatic regs();
    logic [7:0] q;
    apb(1'b0, OFS_CTL1, 8'h00, q);
    chk("ctl1 reset", 16'(CTL1_RST), 16'(q));
    apb(1'b0, OFS_CNT_L, 8'h00, q);
    chk("count reset", 16'(CNT_RST[7:0]), 16'(q));
    apb(1'b0, OFS_RLD_H, 8'h00, q);
    chk("reload reset", 16'(RLD_RST[15:8]), 16'(q));
    apb(1'b1, OFS_CTL0, 8'h08, q);
    apb(1'b0, OFS_CTL0, 8'h00, q);
    chk("cause read only", 16'h0000, 16'(q));
    apb(1'b0, 8'h24, 8'h00, q);
    chk("unmapped err", 16'h0001, 16'(last_err));
    apb(1'b1, OFS_DB, 8'hff, q);
    apb(1'b0, OFS_DB, 8'h00, q);
    chk("deadband clamp", 16'(DB_MAX), 16'(q));
  endtask : regs

  // counts pin high cycles over whole periods
  task automatic dpwm(input logic pol, input logic [2:0] pre, input logic [15:0] pw,
                      input logic [15:0] rl, input logic [7:0] db, input int n);
    int per = int'(rl) << pre;
    int hi = (pol ? int'(pw) : int'(rl - pw)) << pre;
    int no = 0;
    int nc = 0;
    int ni = 0;
    int nb = 0;
    logic [7:0] q;
    cfg({7'h00, CODE_DPWM[3]}, pw, rl, CNT_START);
    apb(1'b1, OFS_DB, db, q);
    apb(1'b1, OFS_CTL1, {1'b1, pol, pre, CODE_DPWM[2:0]}, q);
    wait_for("first reload", timer_irq, 300);
    repeat (n) begin
      @(posedge clk);
      if (pin_out === 1'b1) no++;
      if (pin_cmp === 1'b1) nc++;
      if (timer_irq === 1'b1) ni++;
      if (pin_out === 1'b1 && pin_cmp === 1'b1) nb++;
    end
    chk("out high", 16'(n / per * (hi - int'(db))), 16'(no));
    chk("cmp high", 16'(n / per * (per - hi - int'(db))), 16'(nc));
    chk("reload irq", 16'(n / per), 16'(ni));
    chk("overlap", 16'h0000, 16'(nb));
    chk("cmp oe", 16'h0001, 16'(tcmp_oe));
  endtask : dpwm

  // two active edges 40 clk apart, inactive edge in between
  task automatic cap(input logic rs, input logic pol);
    logic [15:0] v1, v2;
    logic [7:0] q;
    tin_lvl <= pol;
    cfg({7'h00, rs}, 16'h0000, 16'hffff, CNT_START);
    apb(1'b1, OFS_CTL1, {1'b1, pol, 3'h0, rs ? CODE_CAPRS[2:0] : CODE_CAP[2:0]}, q);
    fork
      begin
        repeat (10) @(posedge clk);
        tin_lvl <= ~pol;
        repeat (5) @(posedge clk);
        tin_lvl <= pol;
        repeat (35) @(posedge clk);
        tin_lvl <= ~pol;
        repeat (5) @(posedge clk);
        tin_lvl <= pol;
      end
      begin
        // tight bound: a wrong-polarity capture comes too late
        wait_for("capture irq", timer_irq, 17);
        rd16(OFS_PWM_H, OFS_PWM_L, v1);
        wait_for("capture irq", timer_irq, 60);
        rd16(OFS_PWM_H, OFS_PWM_L, v2);
      end
    join
    chk("capture gap", 16'h0028, rs ? v2 : v2 - v1);
    apb(1'b0, OFS_CTL0, 8'h00, q);
    chk("cause set", 16'h0001, 16'(q[C0_CAUSE]));
    chk("cmp oe", 16'h0000, 16'(tcmp_oe));
  endtask : cap

  task automatic rld(input logic rs);
    logic [15:0] v;
    logic [7:0] q;
    tin_lvl <= 1'b0;
    cfg({7'h00, rs}, 16'h0000, 16'h0108, 16'h0100);
    apb(1'b1, OFS_CTL1, {5'h10, rs ? CODE_CAPRS[2:0] : CODE_CAP[2:0]}, q);
    wait_for("reload irq", timer_irq, 20);
    apb(1'b0, OFS_CTL0, 8'h00, q);
    chk("cause clear", 16'h0000, 16'(q[C0_CAUSE]));
    rd16(OFS_PWM_H, OFS_PWM_L, v);
    chk("pwm kept", 16'h0000, v);
    rd16(OFS_CNT_H, OFS_CNT_L, v);
    chk("count held", rs ? 16'h000c : 16'h0114, v);
  endtask : rld

  // source select masks one event kind; flag and store still work
  task automatic src_sel();
    logic [15:0] v;
    logic [7:0]  q;
    int          ni = 0;
    tin_lvl <= 1'b0;
    cfg({5'h00, SRC_CAP, 1'b0}, 16'h0000, 16'h0108, 16'h0100);
    apb(1'b1, OFS_CTL1, {5'h10, CODE_CAP[2:0]}, q);
    repeat (20) begin
      @(posedge clk);
      if (timer_irq === 1'b1) ni++;
    end
    chk("reload irq masked", 16'h0000, 16'(ni));
    apb(1'b1, OFS_CTL1, 8'h00, q);
    apb(1'b1, OFS_CTL0, {5'h00, SRC_RLD, 1'b0}, q);
    apb(1'b1, OFS_CTL1, {5'h10, CODE_CAP[2:0]}, q);
    tin_lvl <= 1'b1;
    ni = 0;
    repeat (10) begin
      @(posedge clk);
      if (timer_irq === 1'b1) ni++;
    end
    chk("capture irq masked", 16'h0000, 16'(ni));
    apb(1'b0, OFS_CTL0, 8'h00, q);
    chk("masked cause", 16'h0001, 16'(q[C0_CAUSE]));
    rd16(OFS_PWM_H, OFS_PWM_L, v);
    chk("masked store", 16'h0001, 16'(v != 16'h0000));
  endtask : src_sel

  // low clock enable holds the count; six enabled edges between samples
  task automatic freeze();
    logic [15:0] v1, v2;
    rd16(OFS_CNT_H, OFS_CNT_L, v1);
    ce <= 1'b0;
    repeat (50) @(posedge clk);
    ce <= 1'b1;
    rd16(OFS_CNT_H, OFS_CNT_L, v2);
    chk("frozen count", 16'h0006, v2 - v1);
  endtask : freeze

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tin_lvl = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    regs();
    dpwm(1'b0, 3'h0, 16'h0003, 16'h0005, 8'h00, 10);
    dpwm(1'b1, 3'h0, 16'h0003, 16'h0005, 8'h00, 10);
    dpwm(1'b0, 3'h1, 16'h0003, 16'h0005, 8'h00, 20);
    dpwm(1'b0, 3'h0, 16'h0004, 16'h0008, 8'h02, 16);
    cap(1'b0, 1'b0);
    rld(1'b0);
    cap(1'b1, 1'b1);
    rld(1'b1);
    src_sel();
    freeze();
    conclude();
  end
endmodule : tdpc_timer_tb_top
`default_nettype wire
